/* include/slo_pkg.sv */
// constants and carrier types for the stall level select and overload flag block
// ==========================================================================
// Contract
// - warning asserts on stall, held over 100ms
// - warning drops once output at or below level
// - delay 0 immediate, 0.1-25s delayed, 9999 off
// - overvoltage stall drives warning the same way
// - output terminal code 3 high, 103 low
// - 0.5Hz for 3s under stall trips drive
// - high-speed reduction formula above start frequency
// - compensation 9999 keeps base level to 400Hz
// - second frequency 9999 follows second select input
// - frequency mode applies level from 0Hz to setting
// - accelerating always uses base stall level
// - third level only while third select on
// - frequency setting 0 disables that level
// - frequency mode uses smaller of base and second
// - terminal 1 analog yields to second select
// - second level 0% gives zero above frequency
// - input terminal code 3 maps second select
// - terminal 1 code 4 sets analog level
// - terminal 4 code 4 sets level without enable
// - low end at zero, high end at full scale
// - terminal 1 code 4 disables its other functions
// - both analog terminals assigned uses terminal 1
`default_nettype none
package slo_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_HZ               = 40000000;  // system clock rate
  localparam int TICK_PERIOD_MS       = 1;         // time base period
  localparam int TICK_CYCLES          = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int HOLD_TIME_MS         = 100;       // least warning on-time
  localparam int HOLD_TICKS           = HOLD_TIME_MS / TICK_PERIOD_MS;
  localparam int TRIP_TIME_S          = 3;         // stall time before trip
  localparam int TRIP_TICKS           = TRIP_TIME_S * 1000 / TICK_PERIOD_MS;
  localparam int DELAY_UNIT_MS        = 100;       // warning delay step, 0.1 s
  localparam int DELAY_TICKS_PER_UNIT = DELAY_UNIT_MS / TICK_PERIOD_MS;
  // ==========================================================================
  // settings encodings (frequency 0.1 Hz, level 0.1 %, factor 1 %)
  localparam logic [15:0] SETTING_OFF   = 16'h270f;  // 9999
  localparam logic [15:0] FREQ_400HZ    = 16'h0fa0;  // 4000 x 0.1 Hz
  localparam logic [15:0] TRIP_FREQ     = 16'h0005;  // 0.5 Hz
  localparam logic [15:0] COMP_UNITY    = 16'h0064;  // 100 %
  localparam logic [6:0]  PERCENT_SCALE = 7'h64;     // divide by 100
  localparam logic [15:0] TERM_FN_STALL = 16'h0004;  // analog terminal to stall level
  localparam logic [7:0]  IN_FN_SECOND  = 8'h03;     // second function select
  localparam logic [7:0]  IN_FN_THIRD   = 8'h09;     // third function select
  localparam logic [7:0]  OUT_FN_POS    = 8'h03;     // warning, active high
  localparam logic [7:0]  OUT_FN_NEG    = 8'h67;     // 103, warning active low
  localparam logic [11:0] LEVEL_MAX     = 12'hfff;   // saturation of levels
  localparam int          NUM_IN_TERMS  = 12;
  localparam int          NUM_OUT_TERMS = 7;
  localparam int          DIV_W         = 40;        // divider width
  // ==========================================================================
  // reset values
  localparam logic [11:0] LEVEL_RESET   = 12'h5dc;   // 150.0 %
  localparam logic [15:0] TICK_CNT_RST  = 16'h0000;
  // ==========================================================================
  // carrier of all software written settings
  typedef struct packed {
    logic [11:0] baseStallLevel;
    logic [15:0] highSpeedCompFactor;
    logic [15:0] reductionStartFreq;
    logic [11:0] secondStallLevel;
    logic [15:0] secondStallFreq;
    logic [11:0] thirdStallLevel;
    logic [15:0] thirdStallFreq;
    logic [11:0] analogLevelLowEnd;
    logic [11:0] analogLevelHighEnd;
    logic [15:0] warningDelayTimer;
    logic [15:0] terminal4Function;
    logic [15:0] terminal1Function;
    logic        analogRange10V;       // 1: terminal 1 spans 0 to 10 V
  } slo_cfg_s;
  // terminal function maps
  typedef struct packed {
    logic [NUM_IN_TERMS-1:0][7:0]  inFunc;
    logic [NUM_OUT_TERMS-1:0][7:0] outFunc;
  } slo_map_s;
endpackage : slo_pkg
`default_nettype wire

/* rtl/slo_tick_timer.sv */
// tick counting timer with saturating count and done flag
`timescale 1ns/100ps
`default_nettype none
module slo_tick_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tick,     // time base enable
  input  wire logic         run,      // counts while high, clears when low
  input  wire logic [W-1:0] target,   // ticks to reach
  output logic              done,     // run and target reached
  output logic [W-1:0]      count
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         atTarget;

  // ==========================================================================
  // count selection
  assign atTarget   = (count_reg >= target);
  assign count_next = !run ? '0 : (tick && !atTarget) ? count_reg + 1'b1 : count_reg;
  assign done       = run && atTarget;
  assign count      = count_reg;

  // count register, cleared whenever run drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : slo_tick_timer
`default_nettype wire

/* rtl/slo_divider.sv */
// sequential restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
`default_nettype none
module slo_divider (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     start,  // load dividend
  input  wire logic [slo_pkg::DIV_W-1:0] num,
  input  wire logic [slo_pkg::DIV_W-1:0] den,
  output logic                          done,   // one cycle pulse
  output logic [slo_pkg::DIV_W-1:0]     quot    // zero divisor gives all ones
);
  localparam int W = slo_pkg::DIV_W;
  logic [W-1:0] rem_reg;
  logic [W-1:0] quot_reg;
  logic [5:0]   step_reg;
  logic         busy_reg;
  logic         done_reg;
  logic [W:0]   shifted;
  logic         fits;

  // ==========================================================================
  // one restoring step
  assign shifted = {rem_reg, quot_reg[W-1]};
  assign fits    = (shifted >= {1'b0, den});
  assign done    = done_reg;
  assign quot    = quot_reg;

  // iteration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rem_reg  <= '0;
      quot_reg <= '0;
      step_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      rem_reg  <= '0;
      quot_reg <= num;
      step_reg <= '0;
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg) begin
      rem_reg  <= fits ? W'(shifted - {1'b0, den}) : shifted[W-1:0];
      quot_reg <= {quot_reg[W-2:0], fits};
      step_reg <= step_reg + 6'h01;
      busy_reg <= (step_reg != 6'(W - 1));
      done_reg <= (step_reg == 6'(W - 1));
    end else begin
      done_reg <= 1'b0;
    end
  end
endmodule : slo_divider
`default_nettype wire

/* rtl/slo_stall_level_select.sv */
// stall level selection, overload warning and low frequency stall trip
`timescale 1ns/100ps
`default_nettype none
module slo_stall_level_select #(
  parameter int TICK_CYCLES = slo_pkg::TICK_CYCLES  // clocks per 1 ms tick
) (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire slo_pkg::slo_cfg_s                 cfg,
  input  wire slo_pkg::slo_map_s                 termMap,
  input  wire logic [slo_pkg::NUM_IN_TERMS-1:0]  inTerminal,
  input  wire logic [15:0]                       outputFreq,      // 0.1 Hz
  input  wire logic [11:0]                       outputCurrent,   // 0.1 %
  input  wire logic                              accelerating,
  input  wire logic                              overvoltageStall,
  input  wire logic                              terminal4Enable,
  input  wire logic [11:0]                       terminal1Code,   // adc code
  input  wire logic [11:0]                       terminal4Code,   // adc code
  input  wire logic                              faultClear,
  output logic [11:0]                            activeStallLevel,
  output logic                                   overloadWarning,
  output logic [slo_pkg::NUM_OUT_TERMS-1:0]      outTerminal,
  output logic                                   stallTripFault,
  output logic                                   driveStop,
  output logic                                   term1OtherFuncEnable,
  output logic                                   term4FreqCmdEnable
);
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,  // start division for A
    FS_DIVA = 2'b01,  // waiting for A
    FS_DIVB = 2'b10,  // waiting for B
    FS_DIVT = 2'b11   // waiting for correction term
  } slo_fstate_e;

  // ==========================================================================
  // millisecond time base
  logic [15:0] tickCnt_reg;   // divider count
  logic        tick_reg;      // one cycle enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_reg <= slo_pkg::TICK_CNT_RST;
      tick_reg    <= 1'b0;
    end else begin
      tickCnt_reg <= (tickCnt_reg == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tickCnt_reg + 16'h0001;
      tick_reg    <= (tickCnt_reg == 16'(TICK_CYCLES - 1));
    end
  end

  // ==========================================================================
  // terminal function decoding
  logic [slo_pkg::NUM_IN_TERMS-1:0] secHit;  // terminals carrying second select
  logic [slo_pkg::NUM_IN_TERMS-1:0] thdHit;  // terminals carrying third select
  for (genvar i = 0; i < slo_pkg::NUM_IN_TERMS; i++) begin : g_in
    assign secHit[i] = inTerminal[i] && (termMap.inFunc[i] == slo_pkg::IN_FN_SECOND);
    assign thdHit[i] = inTerminal[i] && (termMap.inFunc[i] == slo_pkg::IN_FN_THIRD);
  end
  wire logic secondSel = |secHit;
  wire logic thirdSel  = |thdHit;
  wire logic analogT1  = (cfg.terminal1Function == slo_pkg::TERM_FN_STALL);
  wire logic analogT4  = !analogT1 && (cfg.terminal4Function == slo_pkg::TERM_FN_STALL);
  wire logic analogOn  = analogT1 || analogT4;

  // ==========================================================================
  // analog level interpolation
  wire logic [11:0] anaCode  = analogT1 ? terminal1Code : terminal4Code;
  wire logic        half     = analogT1 && !cfg.analogRange10V;           // 5 V span
  wire logic [12:0] codeSat  = (half && anaCode[11]) ? 13'h0800 : {1'b0, anaCode};
  wire logic signed [13:0] anaSpan =
    $signed({2'b00, cfg.analogLevelHighEnd}) - $signed({2'b00, cfg.analogLevelLowEnd});
  wire logic signed [27:0] anaProd = anaSpan * $signed({1'b0, codeSat});
  wire logic signed [27:0] anaStep = half ? (anaProd >>> 11) : (anaProd >>> 12);
  wire logic signed [27:0] anaSum  = anaStep + $signed({16'h0000, cfg.analogLevelLowEnd});
  wire logic [11:0] analogLevel = (anaSum < 0) ? 12'h000 :
                                  (anaSum > 28'sd4095) ? slo_pkg::LEVEL_MAX : anaSum[11:0];
  wire logic [11:0] baseSel = analogOn ? analogLevel : cfg.baseStallLevel;

  // ==========================================================================
  // high speed reduction arithmetic
  slo_fstate_e  fstate_reg;
  slo_fstate_e  fstate_next;
  logic [11:0]  aReg;          // start*base/freq
  logic [11:0]  bReg;          // start*base/400Hz
  logic [11:0]  reduced_reg;   // reduced level
  logic [11:0]  reduced_next;
  logic         divDone;
  logic [slo_pkg::DIV_W-1:0] divQuot;
  wire logic [27:0] prodStartBase = cfg.reductionStartFreq * baseSel;
  wire logic [11:0] quotSat = (divQuot > 40'(slo_pkg::LEVEL_MAX)) ? slo_pkg::LEVEL_MAX
                                                                   : divQuot[11:0];
  wire logic        compNeg  = (cfg.highSpeedCompFactor < slo_pkg::COMP_UNITY);
  wire logic [15:0] compDiff = compNeg ? slo_pkg::COMP_UNITY - cfg.highSpeedCompFactor
                                       : cfg.highSpeedCompFactor - slo_pkg::COMP_UNITY;
  wire logic [11:0] baseMinusA = (aReg > baseSel) ? 12'h000 : baseSel - aReg;
  wire logic [11:0] baseMinusB = (bReg > baseSel) ? 12'h000 : baseSel - bReg;
  // b as it comes out of its own division, so the term never starts from a stale b
  wire logic [11:0] bCur = (fstate_reg == FS_DIVB) ? quotSat : bReg;
  wire logic [31:0] tNum = bCur * baseMinusA * compDiff[7:0];
  wire logic [18:0] tDenRaw = baseMinusB * slo_pkg::PERCENT_SCALE;
  wire logic [18:0] tDen = (tDenRaw == 19'h00000) ? 19'h00001 : tDenRaw;
  wire logic [12:0] sumUp = {1'b0, aReg} + {1'b0, quotSat};
  wire logic [11:0] corrected = compNeg ? ((quotSat >= aReg) ? 12'h000 : aReg - quotSat)
                                        : (sumUp[12] ? slo_pkg::LEVEL_MAX : sumUp[11:0]);
  wire logic divStart = (fstate_reg == FS_IDLE) || (divDone && fstate_reg != FS_DIVT);
  wire logic [slo_pkg::DIV_W-1:0] divNum =
    (fstate_reg == FS_DIVB) ? {8'h00, tNum} : {12'h000, prodStartBase};
  // the divisor is read on every step, so it follows the division in flight
  wire logic [slo_pkg::DIV_W-1:0] divDen =
    (fstate_reg == FS_DIVA) ? {24'h000000, outputFreq} :
    (fstate_reg == FS_DIVB) ? {24'h000000, slo_pkg::FREQ_400HZ} : {21'h000000, tDen};

  // sequencing of the three divisions
  always_comb begin
    fstate_next  = fstate_reg;
    reduced_next = reduced_reg;
    case (fstate_reg)
      FS_IDLE: fstate_next = FS_DIVA;
      FS_DIVA: if (divDone) begin
        fstate_next = FS_DIVB;
      end
      FS_DIVB: if (divDone) begin
        fstate_next = FS_DIVT;
      end
      default: if (divDone) begin
        fstate_next  = FS_IDLE;
        reduced_next = corrected;
      end
    endcase
  end

  // arithmetic state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fstate_reg  <= FS_IDLE;
      aReg        <= 12'h000;
      bReg        <= 12'h000;
      reduced_reg <= slo_pkg::LEVEL_RESET;
    end else begin
      fstate_reg  <= fstate_next;
      aReg        <= (fstate_reg == FS_DIVA && divDone) ? quotSat : aReg;
      bReg        <= (fstate_reg == FS_DIVB && divDone) ? quotSat : bReg;
      reduced_reg <= reduced_next;
    end
  end

  slo_divider u_div (
    .clk   (clk),
    .rstn  (rstn),
    .start (divStart),
    .num   (divNum),
    .den   (divDen),
    .done  (divDone),
    .quot  (divQuot)
  );

  // ==========================================================================
  // level selection
  wire logic reduceOn = (cfg.highSpeedCompFactor != slo_pkg::SETTING_OFF) &&
                        (outputFreq > cfg.reductionStartFreq) && (baseMinusB != 12'h000);
  wire logic [11:0] hsLevel = reduceOn ? reduced_reg : baseSel;
  wire logic thirdOn  = thirdSel && (cfg.thirdStallFreq != 16'h0000) &&
                        ((cfg.thirdStallFreq == slo_pkg::SETTING_OFF) ||
                         (outputFreq <= cfg.thirdStallFreq));
  wire logic secSignal = secondSel && ((cfg.secondStallFreq == slo_pkg::SETTING_OFF) ||
                                       analogT1);
  wire logic secFreqMode = (cfg.secondStallFreq != 16'h0000) &&
                           (cfg.secondStallFreq != slo_pkg::SETTING_OFF);
  wire logic secInBand = secFreqMode && (outputFreq <= cfg.secondStallFreq);
  wire logic [11:0] secMin = (cfg.secondStallLevel < hsLevel) ? cfg.secondStallLevel
                                                              : hsLevel;
  wire logic secZero = secFreqMode && (cfg.secondStallLevel == 12'h000);
  wire logic [11:0] level_next =
    accelerating ? hsLevel :
    thirdOn      ? cfg.thirdStallLevel :
    secSignal    ? cfg.secondStallLevel :
    secInBand    ? secMin :
    secZero      ? 12'h000 : hsLevel;
  logic [11:0] level_reg;

  // ==========================================================================
  // overload warning and stall trip
  logic        warn_reg;
  logic        fault_reg;
  logic [slo_pkg::NUM_OUT_TERMS-1:0] term_reg;
  logic        delayDone;
  logic        holdDone;
  logic        tripDone;
  logic [15:0] delayCount;
  wire logic engaged   = (outputCurrent > level_reg) || overvoltageStall;
  wire logic suppress  = (cfg.warningDelayTimer == slo_pkg::SETTING_OFF);
  wire logic lowFreq   = (outputFreq <= slo_pkg::TRIP_FREQ);
  wire logic [15:0] delayTarget = 16'(cfg.warningDelayTimer * slo_pkg::DELAY_TICKS_PER_UNIT);
  wire logic delayOk   = (cfg.warningDelayTimer == 16'h0000) || delayDone;
  wire logic warnNext  = suppress ? 1'b0 :
                         (engaged && delayOk) ? 1'b1 :
                         (!engaged && holdDone) ? 1'b0 : warn_reg;
  wire logic faultNext = tripDone || (fault_reg && !faultClear);
  logic [slo_pkg::NUM_OUT_TERMS-1:0] termNext;
  for (genvar j = 0; j < slo_pkg::NUM_OUT_TERMS; j++) begin : g_out
    assign termNext[j] = (termMap.outFunc[j] == slo_pkg::OUT_FN_POS) ? warnNext :
                         (termMap.outFunc[j] == slo_pkg::OUT_FN_NEG) ? !warnNext : 1'b0;
  end

  // delay restarts from zero whenever the overload clears
  slo_tick_timer #(.W(16)) u_delay (
    .clk(clk), .rstn(rstn), .tick(tick_reg), .run(engaged && !suppress),
    .target(delayTarget), .done(delayDone), .count(delayCount)
  );
  // least on-time of the warning
  slo_tick_timer #(.W(16)) u_hold (
    .clk(clk), .rstn(rstn), .tick(tick_reg), .run(warn_reg),
    .target(16'(slo_pkg::HOLD_TICKS)), .done(holdDone), .count()
  );
  // low frequency stall time
  slo_tick_timer #(.W(16)) u_trip (
    .clk(clk), .rstn(rstn), .tick(tick_reg), .run(engaged && lowFreq && !fault_reg),
    .target(16'(slo_pkg::TRIP_TICKS)), .done(tripDone), .count()
  );

  // output registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_reg <= slo_pkg::LEVEL_RESET;
      warn_reg  <= 1'b0;
      fault_reg <= 1'b0;
      term_reg  <= '0;
    end else begin
      level_reg <= level_next;
      warn_reg  <= warnNext;
      fault_reg <= faultNext;
      term_reg  <= termNext;
    end
  end

  // terminal enables
  logic t1Other_reg;
  logic t4Cmd_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t1Other_reg <= 1'b1;
      t4Cmd_reg   <= 1'b0;
    end else begin
      t1Other_reg <= !analogT1;
      t4Cmd_reg   <= terminal4Enable && (cfg.terminal4Function == 16'h0000);
    end
  end

  assign activeStallLevel     = level_reg;
  assign overloadWarning      = warn_reg;
  assign outTerminal          = term_reg;
  assign stallTripFault       = fault_reg;
  assign driveStop            = fault_reg;
  assign term1OtherFuncEnable = t1Other_reg;
  assign term4FreqCmdEnable   = t4Cmd_reg;

  // ==========================================================================
  // checks
  warn_hold_a : assert property (@(posedge clk) disable iff (!rstn)
    $fell(warn_reg) |-> $past(holdDone) || $past(suppress))
    else $error("warning dropped before its least on-time");
  warn_drop_a : assert property (@(posedge clk) disable iff (!rstn)
    warn_reg && !engaged && holdDone |=> !warn_reg)
    else $error("warning stayed on after overload cleared");
  warn_suppress_a : assert property (@(posedge clk) disable iff (!rstn)
    suppress |=> !warn_reg)
    else $error("warning shown while suppressed");
  warn_delay_a : assert property (@(posedge clk) disable iff (!rstn)
    $rose(warn_reg) && $past(cfg.warningDelayTimer) != 16'h0000 |->
    $past(delayCount) >= $past(delayTarget))
    else $error("warning rose before delay elapsed");
  ov_stall_a : assert property (@(posedge clk) disable iff (!rstn)
    overvoltageStall && cfg.warningDelayTimer == 16'h0000 |=> warn_reg)
    else $error("overvoltage stall gave no warning");
  term_polarity_a : assert property (@(posedge clk) disable iff (!rstn)
    termMap.outFunc[1] == slo_pkg::OUT_FN_NEG |=> outTerminal[1] == !warn_reg)
    else $error("negative logic terminal wrong");
  stall_trip_a : assert property (@(posedge clk) disable iff (!rstn)
    tripDone |=> stallTripFault && driveStop)
    else $error("stall trip not raised");
  accel_base_a : assert property (@(posedge clk) disable iff (!rstn)
    accelerating |=> level_reg == $past(hsLevel))
    else $error("accelerating level not base");
  no_second_a : assert property (@(posedge clk) disable iff (!rstn)
    cfg.secondStallFreq == 16'h0000 && !thirdOn && !secSignal |=> level_reg == $past(hsLevel))
    else $error("second level applied while disabled");
  t1_priority_a : assert property (@(posedge clk) disable iff (!rstn)
    analogT1 |-> !analogT4 && anaCode == terminal1Code)
    else $error("terminal 4 used over terminal 1");
  delay_restart_a : assert property (@(posedge clk) disable iff (!rstn)
    !engaged |=> delayCount == 16'h0000)
    else $error("delay timer kept count");
  warn_cover_c  : cover property (@(posedge clk) disable iff (!rstn) $rose(warn_reg));
  trip_cover_c  : cover property (@(posedge clk) disable iff (!rstn) $rose(fault_reg));
  hs_cover_c    : cover property (@(posedge clk) disable iff (!rstn) reduceOn && divDone);
  sec_cover_c   : cover property (@(posedge clk) disable iff (!rstn) secInBand && !accelerating);
endmodule : slo_stall_level_select
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the stall level select and overload flag block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic              clk, rstn, accelerating, overvoltageStall, faultClear;
  slo_pkg::slo_cfg_s cfg;
  slo_pkg::slo_map_s termMap;
  logic [11:0]       inTerminal, outputCurrent, terminal1Code, activeStallLevel, terminal4Code;
  logic              terminal4Enable, term4FreqCmdEnable;
  logic [15:0]       outputFreq;
  logic [6:0]        outTerminal;
  logic              overloadWarning, stallTripFault, driveStop, term1OtherFuncEnable;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  // short tick so every ms timer scales by four clocks
  slo_stall_level_select #(.TICK_CYCLES(4)) uut (.clk(clk), .rstn(rstn), .cfg(cfg),
    .termMap(termMap), .inTerminal(inTerminal), .outputFreq(outputFreq),
    .outputCurrent(outputCurrent), .accelerating(accelerating),
    .overvoltageStall(overvoltageStall), .terminal4Enable(terminal4Enable),
    .terminal1Code(terminal1Code), .terminal4Code(terminal4Code), .faultClear(faultClear),
    .activeStallLevel(activeStallLevel), .overloadWarning(overloadWarning),
    .outTerminal(outTerminal), .stallTripFault(stallTripFault), .driveStop(driveStop),
    .term1OtherFuncEnable(term1OtherFuncEnable), .term4FreqCmdEnable(term4FreqCmdEnable));
  // ==========================================================================
  // helpers
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // inputs change only after a falling edge
  task automatic run(int n);
    repeat (n) @(negedge clk);
  endtask : run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 40000);
    n_mismatch++;
    stop_test();
  end
  // ==========================================================================
  // test sequence
  initial begin
    rstn = 1'b0; accelerating = 1'b0; overvoltageStall = 1'b0; faultClear = 1'b0;
    cfg = '{12'h3e8, 16'h270f, 16'h0fa0, 12'h1f4, 16'h0, 12'h0c8, 16'h0, 12'h0, 12'h7d0,
            16'h0, 16'h0, 16'h0, 1'b1};
    termMap = '0; termMap.inFunc[0] = 8'h03; termMap.inFunc[1] = 8'h09;
    termMap.outFunc[0] = 8'h03; termMap.outFunc[1] = 8'h67;
    inTerminal = '0; outputFreq = 16'h01f4; outputCurrent = 12'h3e8; terminal1Code = 12'h800;
    terminal4Enable = 1'b0; terminal4Code = 12'h800;
    run(8);
    check("rst level", activeStallLevel, 16'h05dc);
    rstn = 1'b1;
    run(200);
    check("base level", activeStallLevel, 16'h03e8);
    outputCurrent = 12'h3e9; run(2);
    check("warn on", overloadWarning, 1'b1);
    check("out terms", outTerminal[1:0], 2'b01);
    outputCurrent = 12'h3e8; run(10);
    check("warn hold", overloadWarning, 1'b1);
    run(400);
    check("warn off", overloadWarning, 1'b0);
    cfg.warningDelayTimer = 16'h0001; outputCurrent = 12'h3e9; run(300);
    outputCurrent = 12'h3e8; run(2);
    outputCurrent = 12'h3e9; run(300);
    check("delay restart", overloadWarning, 1'b0);
    run(120);
    check("delay done", overloadWarning, 1'b1);
    outputCurrent = 12'h3e8; cfg.warningDelayTimer = 16'h0; overvoltageStall = 1'b1; run(420);
    check("ov stall", overloadWarning, 1'b1);
    cfg.warningDelayTimer = slo_pkg::SETTING_OFF; run(2);
    check("warn off code", overloadWarning, 1'b0);
    overvoltageStall = 1'b0; cfg.secondStallFreq = slo_pkg::SETTING_OFF; inTerminal = 12'h001; run(3);
    check("second sel", activeStallLevel, 16'h01f4);
    accelerating = 1'b1; run(3);
    check("accel base", activeStallLevel, 16'h03e8);
    accelerating = 1'b0; cfg.thirdStallFreq = slo_pkg::SETTING_OFF; inTerminal = 12'h003; run(3);
    check("third sel", activeStallLevel, 16'h00c8);
    inTerminal = '0; cfg.secondStallFreq = 16'h0258; run(3);
    check("freq band", activeStallLevel, 16'h01f4);
    outputFreq = 16'h02bc; cfg.secondStallLevel = 12'h0; run(3);
    check("zero level", activeStallLevel, 16'h0000);
    cfg.secondStallFreq = 16'h0; run(3);
    check("freq zero", activeStallLevel, 16'h03e8);
    cfg.highSpeedCompFactor = 16'h00c8; cfg.reductionStartFreq = 16'h0258;
    outputFreq = 16'h04b0; run(300);
    check("hs reduce", activeStallLevel, 16'h024c);
    cfg.highSpeedCompFactor = slo_pkg::SETTING_OFF; run(3);
    check("hs off", activeStallLevel, 16'h03e8);
    cfg.secondStallLevel = 12'h1f4; cfg.terminal1Function = 16'h4; cfg.terminal4Function = 16'h4;
    run(3);
    check("t1 mid", activeStallLevel, 16'h03e8);
    check("t1 other", term1OtherFuncEnable, 1'b0);
    cfg.analogLevelLowEnd = 12'h064; terminal1Code = 12'h000; run(3);
    check("t1 low", activeStallLevel, 16'h0064);
    terminal1Code = 12'h400; run(3);
    check("t1 quarter", activeStallLevel, 16'h023f);
    cfg.analogRange10V = 1'b0; terminal1Code = 12'h800; run(3);
    check("t1 5v full", activeStallLevel, 16'h07d0);
    inTerminal = 12'h001; run(3);
    check("t1 second", activeStallLevel, 16'h01f4);
    inTerminal = '0; cfg.terminal1Function = 16'h0; terminal4Enable = 1'b1; run(3);
    check("t4 mid", activeStallLevel, 16'h041a);
    check("t4 no cmd", term4FreqCmdEnable, 1'b0);
    check("t1 back", term1OtherFuncEnable, 1'b1);
    cfg.terminal4Function = 16'h0; run(3);
    check("t4 cmd", term4FreqCmdEnable, 1'b1);
    inTerminal = '0; overvoltageStall = 1'b1; outputFreq = 16'h0005; run(11900);
    check("no trip yet", stallTripFault, 1'b0);
    run(200);
    check("trip", stallTripFault, 1'b1);
    check("stop", driveStop, 1'b1);
    overvoltageStall = 1'b0; faultClear = 1'b1; run(2);
    check("trip clear", stallTripFault, 1'b0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
